// [logic/bccr_pkg.sv]
package bccr_pkg;
  localparam logic [7:0] BCCR_OFS_VOLTAGE = 8'h20;
  localparam logic [7:0] BCCR_OFS_MODE = 8'h21;
  localparam logic [7:0] BCCR_OFS_RESERVED = 8'h22;
  localparam logic [7:0] BCCR_OFS_ENABLE = 8'h23;
  localparam int BCCR_POS_RANGE = 6;
  localparam int BCCR_POS_MODE = 0;
  localparam int BCCR_POS_ON = 0;
  localparam int BCCR_POS_OK = 1;
  localparam int BCCR_POS_EXACT = 2;
  localparam logic [5:0] BCCR_RST_CODE = 6'h00;
  localparam logic BCCR_RST_RANGE = 1'b1;
  localparam logic BCCR_RST_MODE = 1'b0;
  localparam logic BCCR_RST_ON = 1'b0;
  localparam logic BCCR_RST_EXACT = 1'b0;
  // low range groups 00 and codes 01_0000/01_0001 are not available
  localparam logic [1:0] BCCR_LOW_NA_GROUP = 2'h0;
  localparam logic [5:0] BCCR_LOW_NA_LAST = 6'h11;
  // output voltage in millivolts
  localparam logic [12:0] BCCR_HIGH_BASE_MV = 13'h04E2;
  localparam logic [12:0] BCCR_HIGH_STEP_MV = 13'h0032;
endpackage : bccr_pkg

// [logic/bccr_vlookup.sv]
`timescale 1ns/1ps
module bccr_vlookup
  import bccr_pkg::*;
(
  input wire logic range_in,
  input wire logic [5:0] code_in,
  output logic [12:0] mv_out,
  output logic valid_out
);
  logic [12:0] low_mv [0:63];
  assign low_mv = '{
    13'h0000, 13'h0000, 13'h0000, 13'h0000, 13'h0000, 13'h0000, 13'h0000, 13'h0000,
    13'h0000, 13'h0000, 13'h0000, 13'h0000, 13'h0000, 13'h0000, 13'h0000, 13'h0000,
    13'h0000, 13'h0000, 13'h044C, 13'h0465, 13'h047E, 13'h0497, 13'h04B0, 13'h04C9,
    13'h04E7, 13'h0500, 13'h0519, 13'h0532, 13'h054B, 13'h0564, 13'h057D, 13'h0596,
    13'h05AF, 13'h05C8, 13'h05E1, 13'h05FA, 13'h0613, 13'h0631, 13'h064A, 13'h0663,
    13'h067C, 13'h0695, 13'h06AE, 13'h06C7, 13'h06E0, 13'h06F9, 13'h0712, 13'h072B,
    13'h0744, 13'h0762, 13'h077B, 13'h0794, 13'h07AD, 13'h07C6, 13'h07DF, 13'h07F8,
    13'h0811, 13'h082A, 13'h0843, 13'h085C, 13'h0875, 13'h088E, 13'h0898, 13'h08C5
  };
  logic [12:0] high_mv;
  always_comb begin
    high_mv = BCCR_HIGH_BASE_MV + 13'(BCCR_HIGH_STEP_MV * 13'(code_in));
    if (range_in) begin
      mv_out = high_mv;
      valid_out = 1'b1;
    end else begin
      mv_out = low_mv[code_in];
      valid_out = !(code_in[5:4] == BCCR_LOW_NA_GROUP || code_in <= BCCR_LOW_NA_LAST);
    end
  end
endmodule : bccr_vlookup

// [logic/bccr_regs.sv]
`timescale 1ns/1ps
// How it works
// - four byte locations 20h to 23h hold code/range, mode, a read-only byte and enable/status.
// - the 6-bit code with the range bit picks the output: a 64-entry table in range 0, base plus step in range 1, N/A flagged.
// - range 0 is the low range from 1.1V, with group 00 and codes 01_0000/01_0001 unavailable.
// - range 1 starts at 1.25V for code 0 and adds 50 mV per code up to 4.400 V.
// - bit 7 of 20h, bits 7:1 of 21h, all of 22h and bits 7:3 of 23h are read-only, read as 0.
// - 21h bit 0 picks auto or forced PWM, 23h bit 0 enables, 23h bit 1 shows power good.
// - the converter runs only with its enable bit set and master enable low or power hold high.
module bccr_regs
  import bccr_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  output logic [7:0] rdata_out,
  output logic rvalid_out,
  input wire logic master_enable_n_in,
  input wire logic power_hold_in,
  input wire logic power_good_in,
  output logic run_out,
  output logic forced_pwm_out,
  output logic range_out,
  output logic [5:0] voltage_code_out,
  output logic [12:0] target_mv_out,
  output logic code_valid_out
);
  // host-written state
  logic [5:0] voltage_code;
  logic range_select;
  logic mode;
  logic on;
  logic exact;
  logic [5:0] next_voltage_code;
  logic next_range_select;
  logic next_mode;
  logic next_on;
  logic next_exact;

  // read port state
  logic [7:0] rdata;
  logic rvalid;
  logic [7:0] next_rdata;
  logic next_rvalid;

  // converter run gate
  logic run;
  logic next_run;

  // registered lookup result
  logic [12:0] target_mv;
  logic code_valid;
  logic [12:0] next_target_mv;
  logic next_code_valid;

  // decode and readback wires
  logic hit_voltage;
  logic hit_mode;
  logic hit_reserved;
  logic hit_enable;
  logic [7:0] byte_voltage;
  logic [7:0] byte_mode;
  logic [7:0] byte_enable;
  logic [12:0] lut_mv;
  logic lut_valid;

  // table lookup stays combinational; its result is registered below
  bccr_vlookup u_lookup (
    .range_in(range_select),
    .code_in(voltage_code),
    .mv_out(lut_mv),
    .valid_out(lut_valid)
  );

  // one address decode shared by the write and read paths
  // the reserved byte is decoded only so that its reads are explicit
  always_comb begin
    hit_voltage = (addr_in == BCCR_OFS_VOLTAGE);
    hit_mode = (addr_in == BCCR_OFS_MODE);
    hit_reserved = (addr_in == BCCR_OFS_RESERVED);
    hit_enable = (addr_in == BCCR_OFS_ENABLE);
  end

  // readback bytes; read-only bits return 0 so software sees a fixed value
  // power good shows only while the converter is allowed to run
  always_comb begin
    byte_voltage = 8'h00;
    byte_mode = 8'h00;
    byte_enable = 8'h00;
    byte_voltage[5:0] = voltage_code;
    byte_voltage[BCCR_POS_RANGE] = range_select;
    byte_mode[BCCR_POS_MODE] = mode;
    byte_enable[BCCR_POS_ON] = on;
    byte_enable[BCCR_POS_OK] = power_good_in && run;
    byte_enable[BCCR_POS_EXACT] = exact;
  end

  // write path: only the writable bits of the three mapped bytes take data
  always_comb begin
    next_voltage_code = voltage_code;
    next_range_select = range_select;
    next_mode = mode;
    next_on = on;
    next_exact = exact;
    if (wr_en_in) begin
      if (hit_voltage) begin
        next_voltage_code = wdata_in[5:0];
        next_range_select = wdata_in[BCCR_POS_RANGE];
      end
      if (hit_mode) begin
        next_mode = wdata_in[BCCR_POS_MODE];
      end
      if (hit_enable) begin
        next_on = wdata_in[BCCR_POS_ON];
        // stored as written; keeping it at its default is the host's duty
        next_exact = wdata_in[BCCR_POS_EXACT];
      end
      // reserved byte, read-only bits and unmapped addresses fall through
    end
  end

  // an unavailable code still loads; only code_valid_out warns the host
  // reset picks range 1 so that code 0 selects a valid output
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      voltage_code <= BCCR_RST_CODE;
      range_select <= BCCR_RST_RANGE;
      mode <= BCCR_RST_MODE;
      on <= BCCR_RST_ON;
      exact <= BCCR_RST_EXACT;
    end else begin
      voltage_code <= next_voltage_code;
      range_select <= next_range_select;
      mode <= next_mode;
      on <= next_on;
      exact <= next_exact;
    end
  end

  // read path: data stands until the next read, valid pulses one cycle
  // a read in the same cycle as a write to that byte returns the old value
  always_comb begin
    next_rdata = rdata;
    next_rvalid = 1'b0;
    if (rd_en_in) begin
      next_rvalid = 1'b1;
      if (hit_voltage) begin
        next_rdata = byte_voltage;
      end else if (hit_mode) begin
        next_rdata = byte_mode;
      end else if (hit_enable) begin
        next_rdata = byte_enable;
      end else if (hit_reserved) begin
        next_rdata = 8'h00;
      end else begin
        // unmapped reads still answer, with zero data
        next_rdata = 8'h00;
      end
    end
  end

  // rdata is cleared by reset and by reads of 22h or unmapped addresses; rvalid marks a fresh answer
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rdata <= 8'h00;
      rvalid <= 1'b0;
    end else begin
      rdata <= next_rdata;
      rvalid <= next_rvalid;
    end
  end

  // run gate: pins are taken as synchronous, so no glitch filter here
  // clearing the enable bit stops the converter whatever the pins say
  always_comb begin
    next_run = 1'b0;
    if (on) begin
      // either pin condition alone keeps the converter running
      next_run = !master_enable_n_in || power_hold_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      run <= 1'b0;
    end else begin
      run <= next_run;
    end
  end

  // lookup result lags the code by one register stage
  // the mV value is a nominal target, not a measurement
  always_comb begin
    next_target_mv = lut_mv;
    next_code_valid = lut_valid;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      target_mv <= 13'h0000;
      code_valid <= 1'b0;
    end else begin
      target_mv <= next_target_mv;
      code_valid <= next_code_valid;
    end
  end

  // every output comes straight from a register
  assign rdata_out = rdata;
  assign rvalid_out = rvalid;
  assign run_out = run;
  assign forced_pwm_out = mode;
  assign range_out = range_select;
  assign voltage_code_out = voltage_code;
  assign target_mv_out = target_mv;
  assign code_valid_out = code_valid;
endmodule : bccr_regs

// [verif/bccr_host.sv]
`timescale 1ns/1ps
module bccr_host(
  input wire logic clk_in,
  input wire logic [7:0] rdata_in,
  input wire logic rvalid_in,
  output logic wr_out,
  output logic rd_out,
  output logic [7:0] addr_out,
  output logic [7:0] wdata_out
);
  initial {wr_out, rd_out, addr_out, wdata_out} = '0;
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk_in);
    wr_out <= 1'b1;
    addr_out <= a;
    wdata_out <= (a == 8'h23) ? (d & 8'hFB) : d;
    @(posedge clk_in);
    wr_out <= 1'b0;
    wdata_out <= ~d; // released data never shows the last value
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_in);
    rd_out <= 1'b1;
    addr_out <= a;
    @(posedge clk_in);
    rd_out <= 1'b0;
    // data taken at the edge that sees the valid pulse; no pulse gives unknown data
    @(posedge clk_in);
    d = rvalid_in ? rdata_in : 8'hXX;
  endtask : rd
endmodule : bccr_host

// [verif/bccr_regs_chk.sv]
`timescale 1ns/1ps
module bccr_regs_chk(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic [7:0] rdata_out,
  input wire logic rvalid_out,
  input wire logic master_enable_n_in,
  input wire logic power_hold_in,
  input wire logic power_good_in,
  input wire logic run_out,
  input wire logic forced_pwm_out,
  input wire logic range_out,
  input wire logic [5:0] voltage_code_out,
  input wire logic [12:0] target_mv_out,
  input wire logic code_valid_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  read_answer_a: assert property (rvalid_out == $past(rd_en_in))
    else $error("rvalid");
  code_write_a: assert property (wr_en_in && addr_in == 8'h20 |=>
    {range_out, voltage_code_out} == $past(wdata_in[6:0])) else $error("code");
  high_range_a: assert property (range_out |=> code_valid_out &&
    target_mv_out == 13'h4E2 + 13'h32 * $past(voltage_code_out)) else $error("high");
  low_gap_a: assert property (!range_out && voltage_code_out < 6'h12 |=>
    !code_valid_out && target_mv_out == 13'h0) else $error("gap");
  mode_write_a: assert property (wr_en_in && addr_in == 8'h21 |=>
    forced_pwm_out == $past(wdata_in[0])) else $error("mode");
  run_gate_a: assert property (run_out |->
    $past(!master_enable_n_in || power_hold_in)) else $error("run");
  run_off_a: assert property (wr_en_in && addr_in == 8'h23 && !wdata_in[0] |->
    ##2 !run_out) else $error("run off");
  ro_zero_a: assert property (rd_en_in && addr_in == 8'h22 |=>
    rdata_out == 8'h00) else $error("ro");
  good_read_a: assert property (rd_en_in && addr_in == 8'h23 |=>
    rdata_out[1] == $past(power_good_in && run_out)) else $error("good");
  cover property (run_out);
  cover property (!range_out && code_valid_out);
  cover property (rd_en_in && addr_in == 8'h23);
endmodule : bccr_regs_chk
bind bccr_regs bccr_regs_chk u_chk (.*);

// [verif/bccr_regs_tb.sv]
`timescale 1ns/1ps
module bccr_regs_tb;
  logic clk_in = 1'b0, rst_in = 1'b1, wr_en_in, rd_en_in, rvalid_out, run_out, range_out;
  logic master_enable_n_in = 1'b1, power_hold_in = 1'b0, power_good_in = 1'b0;
  logic forced_pwm_out, code_valid_out;
  logic [7:0] addr_in, wdata_in, rdata_out, d;
  logic [5:0] voltage_code_out;
  logic [12:0] target_mv_out;
  int num_errors = 0, num_checks = 0, e;
  initial forever #2.5 clk_in = ~clk_in;
  bccr_host u_host(.clk_in(clk_in), .rdata_in(rdata_out), .rvalid_in(rvalid_out), .wr_out(wr_en_in),
    .rd_out(rd_en_in), .addr_out(addr_in), .wdata_out(wdata_in));
  bccr_regs u_dut (.*);
  task automatic chk(input string n, input logic [31:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, exp, got);
    end
  endtask : chk
  function automatic int model_mv(int r, int c);
    if (r) return 1250 + 50 * c;
    if (c < 18) return 0;
    if (c > 61) return (c == 62) ? 2200 : 2245;
    return 650 + 25 * c + 5 * ((c > 23) + (c > 36) + (c > 48)); // uneven printed steps
  endfunction : model_mv
  task automatic report_and_stop;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop
  initial begin
    #100000;
    num_errors++;
    report_and_stop();
  end
  initial begin
    void'($urandom(32'hFC5F));
    repeat (20) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    chk("reset", {range_out, voltage_code_out, code_valid_out, target_mv_out},
      {8'h81, 13'h4E2});
    for (int i = 0; i < 128; i++) begin
      u_host.wr(8'h20, {1'($urandom), i[6:0]});
      u_host.rd(8'h20, d);
      e = model_mv(i / 64, i % 64);
      chk("code", {range_out, voltage_code_out, code_valid_out, target_mv_out},
        {i[6:0], e != 0, e[12:0]});
      chk("rd20", d, {1'b0, i[6:0]});
    end
    for (int i = 0; i < 2; i++) begin
      u_host.wr(8'h21, {7'($urandom), i[0]});
      u_host.rd(8'h21, d);
      chk("mode", {forced_pwm_out, d}, {i[0], 7'h0, i[0]});
    end
    u_host.wr(8'h22, 8'hFF);
    u_host.rd(8'h22, d);
    chk("ro", d, 8'h00);
    u_host.rd(8'h30, d);
    chk("unmapped", d, 8'h00);
    for (int i = 0; i < 16; i++) begin
      @(posedge clk_in);
      master_enable_n_in <= i[1];
      power_hold_in <= i[2];
      power_good_in <= i[3];
      u_host.wr(8'h23, {5'($urandom), 2'h0, i[0]});
      u_host.rd(8'h23, d);
      e = i[0] && (!i[1] || i[2]);
      chk("enable", {run_out, d}, {e[0], 6'h0, i[3] && e[0], i[0]});
    end
    report_and_stop();
  end
endmodule : bccr_regs_tb
